// [hdl/fpc_flash_prot.sv]
// command decoder, protection state and flash map for the embedded flash
//
// Notes on behaviour
// R1: decode set and read protection: A8,54 then C0/90 at 2A54/15A8/2A54, 4th at odd word.
// R2: block unprotect is prefix, C1 at 2A54, then F0 anywhere; A14 upward ignored.
// R3: zero in bit 15 protects code, zero in bit N protects block N.
// R4: flag write error when word tries to return a programmed zero to one.
// R5: single FFFF write to flash, absolute mode, from flash code lifts code protection.
// R6: single FFFB write from flash-resident code restores code protection.
// R7: erase accepts extra blocks within 96 us; timeout state shown in status bit 3.
// R8: host polls data-polling or toggle bit until erase ends or suspends.
// R9: command sequences fetched from the flash itself are refused.
// R10: pauses between command cycles are allowed; state is held.
// R11: reads inside a sequence at unused positions return dummy data.
// R12: host uses register-indirect addressing for every command cycle.
// R13: command address includes segment or data page pointer contribution.
// R14: reset lengthening is never shown on the bidirectional reset pin.
// R15: reset lengthening is disabled when starting from external memory.
// R16: external access pin sampled at reset into internal memory enable bit.
// R17: flash disabled while internal memory enable is 0, enabled when set.
// R18: low block remap 0 maps first 32 Kbytes into segment 1.
// R19: remap affects only the first 32 Kbytes; 01'8000..04'FFFF fixed.
// R20: full 256 Kbytes alongside external boot only with segmentation disable 0.
// R21: software jumps inter-segment and reloads page pointers after map changes.
// R22: code enabling segment-0 flash runs above 00'8000 or from RAM.
// R23: any system reset clears the temporary code-unprotected state.
// R24: protection bits are permanent once programmed; no clear operation. The model reloads PROT_RST (all ones) on every reset.
// R25: a mismatching command cycle abandons the sequence to array read.
`timescale 1ns/1ns
module fpc_flash_prot
  import fpc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_wr, // write cycle strobe, one cycle
  input wire logic i_rd, // read cycle strobe, one cycle
  input wire logic [23:0] i_addr, // physical address, page pointer already applied
  input wire logic [15:0] i_wdata,
  input wire logic i_fetch_flash, // issuing instruction fetched from flash
  input wire logic i_indirect, // register-indirect addressing
  input wire logic i_absolute, // absolute addressing
  input wire logic i_erase_entry, // block erase entry write, restarts window
  input wire logic i_erase_active, // block erase sequence collecting blocks
  input wire logic i_ext_access_pin, // level of external access pin
  input wire logic i_mem_en_wr, // software write of internal memory enable
  input wire logic i_mem_en_val,
  input wire logic i_low_block_remap,
  input wire logic i_segmentation_disable,
  input wire logic i_reset_lengthen_req, // flash asks to lengthen cpu reset
  output logic [15:0] o_rdata,
  output logic o_rdata_dummy,
  output logic [15:0] o_protection_register,
  output logic o_code_protected,
  output logic o_code_temp_unprot,
  output logic o_block_temp_unprot,
  output logic o_write_error,
  output logic [15:0] o_flash_status_word,
  output logic o_internal_memory_enable,
  output logic o_flash_hit,
  output logic [23:0] o_flash_offset,
  output logic o_cpu_reset_extend,
  output logic o_reset_pin_oe
);

  // ==========================================================
  // cycle qualification
  fpc_state_t state_r;
  logic [13:0] cadr;
  logic [7:0] cdat;
  logic cmd_wr;
  logic odd_word;
  logic [15:0] prot_r;
  logic ctu_r;
  logic btu_r;
  logic err_r;
  logic [15:0] rdata_r;
  logic dummy_r;
  logic mem_en_r;
  logic boot_seen_r;
  logic int_start_r; // boot source caught from the strap, never from software
  logic [$clog2(ERASE_TMO_CYC+1)-1:0] tmo_cnt_r;
  logic tmo_open_r;

  // compare only low address bits; physical address already holds pointer part
  assign cadr = i_addr[CMD_ABITS-1:0]; // R2 R13
  assign cdat = i_wdata[7:0];
  // sequences only from ram or external code, indirect only
  assign cmd_wr = i_wr && !i_fetch_flash && i_indirect; // R9 R12
  // odd word address is 4n-2: byte address bit 1 set, bit 0 clear
  assign odd_word = i_addr[1] && !i_addr[0]; // R1

  // ==========================================================
  // command sequencer
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r <= FPC_IDLE;
    end else if (cmd_wr) begin // R10
      case (state_r)
        FPC_IDLE, FPC_RDPROT: begin
          state_r <= (cadr == ADDR_A && cdat == DAT_UNLOCK1) ? FPC_UNL1 : FPC_IDLE; // R25
        end
        FPC_UNL1: begin
          state_r <= (cadr == ADDR_B && cdat == DAT_UNLOCK2) ? FPC_UNL2 : FPC_IDLE; // R25
        end
        FPC_UNL2: begin
          if (cadr == ADDR_A && cdat == DAT_SETPROT) begin // R1
            state_r <= FPC_SETP;
          end else if (cadr == ADDR_A && cdat == DAT_BTU) begin // R2
            state_r <= FPC_BTU;
          end else if (cadr == ADDR_A && cdat == DAT_RDPROT) begin // R1
            state_r <= FPC_RDPROT;
          end else begin
            state_r <= FPC_IDLE; // R25
          end
        end
        default: begin
          state_r <= FPC_IDLE;
        end
      endcase
    end
  end

  // read protection: 4th cycle is a read at an odd word address
  logic rdprot_read;
  assign rdprot_read = i_rd && state_r == FPC_RDPROT && odd_word;

  // ==========================================================
  // protection register: writes only clear bits, reset reloads all ones
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      prot_r <= PROT_RST;
    end else if (cmd_wr && state_r == FPC_SETP && odd_word) begin
      prot_r <= prot_r & i_wdata; // R3 R24
    end
  end

  // write error sticky until reset
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      err_r <= 1'b0;
    end else if (cmd_wr && state_r == FPC_SETP && odd_word && |(i_wdata & ~prot_r)) begin
      err_r <= 1'b1; // R4
    end
  end

  // temporary code unprotect / protect from flash-resident code
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctu_r <= 1'b0; // R23
    end else if (i_wr && i_fetch_flash && i_absolute && o_flash_hit) begin
      if (i_wdata == DAT_CTU) begin
        ctu_r <= 1'b1; // R5
      end else if (i_wdata == DAT_CTP) begin
        ctu_r <= 1'b0; // R6
      end
    end
  end

  // block temporary unprotect, cleared by reset
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      btu_r <= 1'b0;
    end else if (cmd_wr && state_r == FPC_BTU && cdat == DAT_RESET) begin
      btu_r <= 1'b1; // R2
    end
  end

  // ==========================================================
  // read data path
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_r <= DUMMY_DATA;
      dummy_r <= 1'b0;
    end else if (i_rd) begin
      if (rdprot_read) begin
        rdata_r <= prot_r; // R1
        dummy_r <= 1'b0;
      end else if (state_r != FPC_IDLE) begin
        rdata_r <= DUMMY_DATA; // R11
        dummy_r <= 1'b1;
      end else begin
        rdata_r <= o_flash_status_word;
        dummy_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // block erase accept window
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      tmo_cnt_r <= '0;
      tmo_open_r <= 1'b0;
    end else if (i_erase_entry) begin
      tmo_cnt_r <= ($bits(tmo_cnt_r))'(ERASE_TMO_CYC); // R7
      tmo_open_r <= 1'b1;
    end else if (!i_erase_active) begin
      tmo_open_r <= 1'b0;
      tmo_cnt_r <= '0;
    end else if (tmo_cnt_r != '0) begin
      tmo_cnt_r <= tmo_cnt_r - 1'b1;
      tmo_open_r <= (tmo_cnt_r != ($bits(tmo_cnt_r))'(1));
    end
  end

  // status word: timeout bit high once window expired
  always_comb begin
    o_flash_status_word = '0;
    o_flash_status_word[FSW_TMO_BIT] = i_erase_active && !tmo_open_r; // R7
    o_flash_status_word[FSW_ERR_BIT] = err_r;
  end

  // ==========================================================
  // memory enable: strap caught on reset, software may change later
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      boot_seen_r <= 1'b0;
      mem_en_r <= 1'b0;
      int_start_r <= 1'b0;
    end else if (!boot_seen_r) begin
      boot_seen_r <= 1'b1;
      mem_en_r <= i_ext_access_pin; // R16
      int_start_r <= i_ext_access_pin; // R15
    end else if (i_mem_en_wr) begin
      mem_en_r <= i_mem_en_val; // R17
    end
  end

  // address map
  always_comb begin
    o_flash_hit = 1'b0;
    o_flash_offset = '0;
    if (mem_en_r) begin // R17
      if (i_addr >= FIXED_LO && i_addr <= FIXED_HI) begin
        o_flash_hit = 1'b1; // R19
        o_flash_offset = i_addr;
      end else if (!i_low_block_remap && i_addr >= SEG1_BASE && i_addr < SEG1_END) begin
        o_flash_hit = !i_segmentation_disable; // R18 R20
        o_flash_offset = i_addr - SEG1_BASE;
      end else if (i_low_block_remap && i_addr < LOW_BLOCK_SIZE) begin
        o_flash_hit = 1'b1; // R18
        o_flash_offset = i_addr;
      end
    end
  end

  // reset lengthening: internal only, off for external start; the boot source is the pin level
  // while reset is held and the caught strap afterwards, so a later software enable does not count
  logic int_start;
  assign int_start = i_srst ? i_ext_access_pin : int_start_r;
  assign o_cpu_reset_extend = i_reset_lengthen_req && int_start; // R15
  assign o_reset_pin_oe = 1'b0; // R14

  assign o_rdata = rdata_r;
  assign o_rdata_dummy = dummy_r;
  assign o_protection_register = prot_r;
  assign o_code_protected = !prot_r[PROT_CODE_BIT] && !ctu_r; // R3
  assign o_code_temp_unprot = ctu_r;
  assign o_block_temp_unprot = btu_r;
  assign o_write_error = err_r;
  assign o_internal_memory_enable = mem_en_r;

  // ==========================================================
  // checks
  a_prot_only_clears: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R24
    1'b1 |=> ((prot_r & ~$past(prot_r)) == '0)) else $error("protection bit returned to one");
  a_setp_path: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R1
    (cmd_wr && state_r == FPC_UNL2 && cadr == ADDR_A && cdat == DAT_SETPROT) |=> state_r == FPC_SETP)
    else $error("set protection not entered");
  a_err_flag: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R4
    (cmd_wr && state_r == FPC_SETP && odd_word && |(i_wdata & ~prot_r)) |=> o_write_error)
    else $error("write error not flagged");
  a_ctu_set: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R5
    (i_wr && i_fetch_flash && i_absolute && o_flash_hit && i_wdata == DAT_CTU) |=> ctu_r)
    else $error("temporary unprotect missed");
  a_ctp_set: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R6
    (i_wr && i_fetch_flash && i_absolute && o_flash_hit && i_wdata == DAT_CTP) |=> !ctu_r)
    else $error("temporary protect missed");
  a_flash_fetch_ignored: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R9
    (i_wr && i_fetch_flash) |=> $stable(state_r)) else $error("flash fetched command taken");
  a_hold_state: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R10
    (!i_wr) |=> $stable(state_r)) else $error("sequence state lost in pause");
  a_dummy_read: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R11
    (i_rd && state_r inside {FPC_UNL1, FPC_UNL2, FPC_SETP, FPC_BTU}) |=> o_rdata == DUMMY_DATA)
    else $error("no dummy read data");
  a_abandon: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R25
    (cmd_wr && state_r == FPC_UNL1 && cadr != ADDR_B) |=> state_r == FPC_IDLE)
    else $error("bad cycle not abandoned");
  a_reset_pin_quiet: assert property (@(posedge i_ref_clk) !o_reset_pin_oe) // R14
    else $error("reset pin driven");
  a_ctu_reset: assert property (@(posedge i_ref_clk) i_srst |=> !ctu_r) // R23
    else $error("unprotect survived reset");
  a_btu_set: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R2
    (cmd_wr && state_r == FPC_BTU && cdat == DAT_RESET) |=> o_block_temp_unprot)
    else $error("block temporary unprotect missed");
  a_window_open: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R7
    (i_erase_entry && i_erase_active) |=> !o_flash_status_word[FSW_TMO_BIT])
    else $error("erase window not reopened");
  a_ext_start_quiet: assert property (@(posedge i_ref_clk) disable iff (i_srst) // R15
    (boot_seen_r && !int_start_r && i_mem_en_wr) |=> !o_cpu_reset_extend)
    else $error("reset lengthened after external start");
  c_set_prot: cover property (@(posedge i_ref_clk) state_r == FPC_SETP ##[1:20] o_write_error);
  c_read_prot: cover property (@(posedge i_ref_clk) rdprot_read);
  c_btu: cover property (@(posedge i_ref_clk) $rose(btu_r));
  c_ctu: cover property (@(posedge i_ref_clk) $rose(ctu_r));

endmodule

// [hdl/fpc_pkg.sv]
// constants for the flash protection command interface
package fpc_pkg;
  // coded command addresses, only bits 13..0 compared
  localparam int CMD_ABITS = 14;
  localparam logic [13:0] ADDR_A = 14'h2A54;
  localparam logic [13:0] ADDR_B = 14'h15A8;
  // command data bytes (low byte compared)
  localparam logic [7:0] DAT_UNLOCK1 = 8'hA8;
  localparam logic [7:0] DAT_UNLOCK2 = 8'h54;
  localparam logic [7:0] DAT_SETPROT = 8'hC0;
  localparam logic [7:0] DAT_RDPROT = 8'h90;
  localparam logic [7:0] DAT_BTU = 8'hC1;
  localparam logic [7:0] DAT_RESET = 8'hF0;
  // single-cycle code protection words
  localparam logic [15:0] DAT_CTU = 16'hFFFF;
  localparam logic [15:0] DAT_CTP = 16'hFFFB;
  // protection word layout
  localparam int PROT_CODE_BIT = 15;
  localparam logic [15:0] PROT_RST = 16'hFFFF;
  // dummy read data
  localparam logic [15:0] DUMMY_DATA = 16'hFFFF;
  // flash status word: erase timeout bit and write error bit
  localparam int FSW_TMO_BIT = 3;
  localparam int FSW_ERR_BIT = 5;
  // block erase accept window
  localparam int CLK_MHZ = 25;
  localparam int ERASE_TMO_US = 96;
  localparam int ERASE_TMO_CYC = ERASE_TMO_US * CLK_MHZ;
  // memory map
  localparam logic [23:0] LOW_BLOCK_SIZE = 24'h00_8000;
  localparam logic [23:0] SEG1_BASE = 24'h01_0000;
  localparam logic [23:0] FIXED_LO = 24'h01_8000;
  localparam logic [23:0] FIXED_HI = 24'h04_FFFF;
  localparam logic [23:0] SEG1_END = 24'h01_8000;
  // sequencer states
  typedef enum logic [5:0] {
    FPC_IDLE   = 6'b000001,
    FPC_UNL1   = 6'b000010,
    FPC_UNL2   = 6'b000100,
    FPC_SETP   = 6'b001000,
    FPC_BTU    = 6'b010000,
    FPC_RDPROT = 6'b100000
  } fpc_state_t;
endpackage

// [test/fpc_cpu_model.sv]
// processor core model that issues flash command and read cycles
`timescale 1ns/1ns
module fpc_cpu_model (
  input wire logic i_ref_clk,
  output logic o_wr = 1'h0,
  output logic o_rd = 1'h0,
  output logic [23:0] o_addr = 24'h00_0000,
  output logic [15:0] o_wdata = 16'h0000,
  output logic o_fetch_flash = 1'h0,
  output logic o_indirect = 1'h0,
  output logic o_absolute = 1'h0
);
  // ====
  // bus cycle: held for one edge, then released with inverted lines
  task automatic cyc(input logic w, input logic [23:0] a, input logic [15:0] d, input logic [2:0] m);
    @(posedge i_ref_clk);
    o_wr <= w;
    o_rd <= ~w;
    o_addr <= a;
    o_wdata <= d;
    {o_fetch_flash, o_indirect, o_absolute} <= m;
    @(posedge i_ref_clk);
    o_wr <= 1'h0;
    o_rd <= 1'h0;
    o_addr <= ~a;
    o_wdata <= ~d;
    {o_fetch_flash, o_indirect, o_absolute} <= ~m;
    #1;
  endtask
  // park the address with no strobe, for map lookups
  task automatic aim(input logic [23:0] a);
    @(posedge i_ref_clk);
    o_addr <= a;
    #1;
  endtask
endmodule

// [test/fpc_flash_prot_tb.sv]
// self-checking bench for the flash protection command interface
`timescale 1ns/1ns
module fpc_flash_prot_tb
  import fpc_pkg::*;
;
  // ====
  // modes {from flash, indirect, absolute}
  localparam logic [2:0] M_CMD = 3'h2;
  localparam logic [2:0] M_FL = 3'h5;
  localparam logic [2:0] M_BAD = 3'h6;
  localparam logic [2:0] M_DIR = 3'h0;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic er_entry = 1'h0;
  logic er_act = 1'h0;
  logic ext_pin = 1'h1;
  logic men_wr = 1'h0;
  logic men_val = 1'h0;
  logic remap = 1'h1;
  logic seg_dis = 1'h0;
  logic len_req = 1'h1;
  logic wr, rd, ff, ind, ab, dummy, cprot, code_temp_unprotect, block_temp_unprotect, werr, memen, hit, rext, rpoe;
  logic [23:0] addr, offs;
  logic [15:0] wdata, rdata, prot, fsw;
  int n_mismatch = 0;
  int samples_checked = 0;
  int waited = 0;
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] prot;
    logic err;
  } fpc_row_t;
  fpc_row_t rows [3] = '{'{16'hFFFE, 16'hFFFE, 1'h0}, '{16'h7FFE, 16'h7FFE, 1'h0}, '{16'h7FFF, 16'h7FFE, 1'h1}};
  // clock
  always #20 ref_clk = ~ref_clk;
  fpc_cpu_model fpc_cpu_model_i (.i_ref_clk(ref_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .o_fetch_flash(ff), .o_indirect(ind), .o_absolute(ab));
  fpc_flash_prot fpc_flash_prot_i (.i_ref_clk(ref_clk), .i_srst(srst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .i_fetch_flash(ff), .i_indirect(ind), .i_absolute(ab), .i_erase_entry(er_entry),
    .i_erase_active(er_act), .i_ext_access_pin(ext_pin), .i_mem_en_wr(men_wr), .i_mem_en_val(men_val),
    .i_low_block_remap(remap), .i_segmentation_disable(seg_dis), .i_reset_lengthen_req(len_req),
    .o_rdata(rdata), .o_rdata_dummy(dummy), .o_protection_register(prot), .o_code_protected(cprot),
    .o_code_temp_unprot(code_temp_unprotect), .o_block_temp_unprot(block_temp_unprotect), .o_write_error(werr), .o_flash_status_word(fsw),
    .o_internal_memory_enable(memen), .o_flash_hit(hit), .o_flash_offset(offs), .o_cpu_reset_extend(rext),
    .o_reset_pin_oe(rpoe));
  // compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic tally_and_finish();
    $display("mismatches=%0d checked=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // bus shorthands
  task automatic put(input logic [23:0] a, input logic [15:0] d, input logic [2:0] m);
    fpc_cpu_model_i.cyc(1'h1, a, d, m);
  endtask
  task automatic get(input logic [23:0] a);
    fpc_cpu_model_i.cyc(1'h0, a, 16'h0000, M_CMD);
  endtask
  task automatic tick();
    @(posedge ref_clk);
  endtask
  task automatic do_reset();
    tick();
    srst <= 1'h1;
    repeat (5) tick();
    srst <= 1'h0;
    repeat (2) tick();
    #1;
  endtask
  // unlock prefix; upper address bits set on purpose
  task automatic pre(input logic [7:0] c, input logic [2:0] m);
    put(24'h00_6A54, 16'h00A8, m);
    put(24'h00_15A8, 16'h0054, m);
    put(24'h00_EA54, {8'h00, c}, m);
  endtask
  // ====
  // main sequence
  initial begin
    do_reset();
    chkb(memen, 1'h1);
    chk(prot, PROT_RST);
    chk(rdata, DUMMY_DATA);
    chkb(rpoe, 1'h0);
    chkb(rext, 1'h1);
    foreach (rows[k]) begin
      pre(DAT_SETPROT, M_CMD);
      put(24'h00_0006, rows[k].word, M_CMD);
      chk(prot, rows[k].prot);
      chkb(werr, rows[k].err);
    end
    chkb(fsw[FSW_ERR_BIT], 1'h1);
    chkb(cprot, 1'h1);
    // commands fetched from flash are ignored
    pre(DAT_SETPROT, M_BAD);
    put(24'h00_0006, 16'h0000, M_BAD);
    chk(prot, 16'h7FFE);
    // commands with direct addressing are ignored as well
    pre(DAT_SETPROT, M_DIR);
    put(24'h00_0006, 16'h0000, M_DIR);
    chk(prot, 16'h7FFE);
    // wrong second cycle drops the sequence
    put(24'h00_2A54, 16'h00A8, M_CMD);
    put(24'h00_15A8, 16'h0055, M_CMD);
    put(24'h00_2A54, 16'h00C0, M_CMD);
    put(24'h00_0006, 16'h0000, M_CMD);
    chk(prot, 16'h7FFE);
    // read protection with a stray read inside the sequence
    put(24'h00_2A54, 16'h00A8, M_CMD);
    get(24'h00_1000);
    chk(rdata, DUMMY_DATA);
    chkb(dummy, 1'h1);
    put(24'h00_15A8, 16'h0054, M_CMD);
    put(24'h00_2A54, 16'h0090, M_CMD);
    repeat (2) begin
      get(24'h00_000A);
      chk(rdata, 16'h7FFE);
    end
    chkb(dummy, 1'h0);
    pre(DAT_BTU, M_CMD);
    put(24'h03_3333, 16'h00F0, M_CMD);
    chkb(block_temp_unprotect, 1'h1);
    // temporary code unprotect and protect
    put(24'h02_0000, DAT_CTU, M_CMD);
    chkb(code_temp_unprotect, 1'h0);
    put(24'h02_0000, DAT_CTU, M_FL);
    chkb(code_temp_unprotect, 1'h1);
    chkb(cprot, 1'h0);
    put(24'h02_0002, DAT_CTP, M_FL);
    chkb(cprot, 1'h1);
    put(24'h02_0000, DAT_CTU, M_FL);
    tick();
    ext_pin <= 1'h0;
    len_req <= 1'h1;
    do_reset();
    chkb(code_temp_unprotect, 1'h0);
    chkb(memen, 1'h0);
    chkb(rext, 1'h0);
    fpc_cpu_model_i.aim(24'h02_0000);
    chkb(hit, 1'h0);
    tick();
    men_wr <= 1'h1;
    men_val <= 1'h1;
    tick();
    men_wr <= 1'h0;
    #1;
    chkb(memen, 1'h1);
    fpc_cpu_model_i.aim(24'h02_0000);
    chkb(hit, 1'h1);
    chkb(rext, 1'h0);
    // low block mapping
    fpc_cpu_model_i.aim(24'h01_0004);
    chkb(hit, 1'h0);
    remap <= 1'h0;
    fpc_cpu_model_i.aim(24'h01_0004);
    chkb(hit, 1'h1);
    chk(offs[15:0], 16'h0004);
    seg_dis <= 1'h1;
    fpc_cpu_model_i.aim(24'h02_0000);
    chkb(hit, 1'h1);
    fpc_cpu_model_i.aim(24'h01_0004);
    chkb(hit, 1'h0);
    // block erase accept window
    tick();
    er_act <= 1'h1;
    er_entry <= 1'h1;
    tick();
    er_entry <= 1'h0;
    repeat (ERASE_TMO_CYC - 100) tick();
    #1;
    chkb(fsw[FSW_TMO_BIT], 1'h0);
    // poll the status word until the accept window closes, bounded
    for (waited = 0; waited < 200 && !fsw[FSW_TMO_BIT]; waited++) begin
      tick();
      #1;
    end
    chk(waited[15:0], 16'h0064);
    chkb(fsw[FSW_TMO_BIT], 1'h1);
    tick();
    er_entry <= 1'h1;
    tick();
    er_entry <= 1'h0;
    #1;
    chkb(fsw[FSW_TMO_BIT], 1'h0);
    tally_and_finish();
  end
  // cut a hung run short
  initial begin
    repeat (20000) tick();
    n_mismatch++;
    tally_and_finish();
  end
endmodule
